// [hdl/ecs_checker.sv]
// module: enclave control structure checker and holder (device end)
`timescale 1ns/100ps
module ecs_checker #(
  parameter logic [63:0] ATTR_PERMIT = 64'h0000_0000_0000_0037, // enumerated permitted attributes
  parameter logic [31:0] EXTRA_CAP   = 32'h0000_0001            // enumerated extra-state capability
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  ecs_if.dev                lnk,
  output logic              valid_o,
  output logic [63:0]       size_o,
  output logic [63:0]       base_o,
  output logic [31:0]       frame_pages_o,
  output logic [127:0]      attrib_o,
  output logic [255:0]      build_meas_o,
  output logic [255:0]      signer_meas_o,
  output logic [63:0]       enclave_ident_o
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // power-of-two test; zero is not a power of two
  function automatic logic pow2(input logic [63:0] v);
    return (v != 64'h0) && ((v & (v - 64'h1)) == 64'h0);
  endfunction : pow2

  // measurement step: rotate left by one and fold in new data
  function automatic logic [255:0] fold(input logic [255:0] acc, input logic [255:0] din);
    return {acc[254:0], acc[255]} ^ din;
  endfunction : fold

  // stored selection vector and running ident counter
  logic [31:0]  sel_q;
  logic [63:0]  ident_ctr_q;

  // one flag per create check
  logic         addr_misaligned;
  logic         size_not_pow2;
  logic         base_misaligned;
  logic         frame_empty;
  logic         init_preset;
  logic         attr_unpermitted;
  logic         select_uncapable;
  logic         select_reserved;
  logic         area_dirty;
  logic         create_bad;

  // operation decode and verdict
  logic         is_create;
  logic         other_bad;
  logic         bad;
  logic         commit;
  logic         exit_save;
  logic         result_ok;

  // create checks; any raised flag refuses the create
  always_comb begin
    addr_misaligned  = lnk.struct_addr[ecs_pkg::ALIGN_BITS-1:0] != 12'h000;
    size_not_pow2    = !pow2(lnk.size);
    base_misaligned  = (lnk.base & (lnk.size - 64'h1)) != 64'h0;
    frame_empty      = lnk.frame_pages == 32'h0;
    init_preset      = lnk.attrib[ecs_pkg::ATTR_INIT_BIT];
    attr_unpermitted = (lnk.attrib[63:0] & ~(ATTR_PERMIT & ecs_pkg::ATTR_DEFINED_MASK)) != 64'h0;
    select_uncapable = (EXTRA_CAP == 32'h0) && (lnk.extra_select != 32'h0);
    select_reserved  = (lnk.extra_select & ~ecs_pkg::SEL_DEFINED_MASK) != 32'h0;
    area_dirty       = !lnk.reserved_zero;
    create_bad       = addr_misaligned || size_not_pow2 || base_misaligned || frame_empty
                    || init_preset || attr_unpermitted || select_uncapable
                    || select_reserved || area_dirty;
  end

  // verdict per operation; a refusal blocks every commit
  always_comb begin
    is_create = lnk.op == ecs_pkg::ECS_OP_CREATE;
    other_bad = 1'b0;
    unique case (lnk.op)
      ecs_pkg::ECS_OP_CREATE: other_bad = create_bad;
      ecs_pkg::ECS_OP_INIT:   other_bad = !valid_o || attrib_o[ecs_pkg::ATTR_INIT_BIT];
      ecs_pkg::ECS_OP_EXTEND: other_bad = !valid_o || attrib_o[ecs_pkg::ATTR_INIT_BIT];
      ecs_pkg::ECS_OP_REPORT: other_bad = !valid_o || !lnk.attrib[ecs_pkg::ATTR_INIT_BIT]
                                          || !lnk.reserved_zero;
      default:                other_bad = !valid_o;
    endcase
    bad       = other_bad;
    commit    = lnk.req && !bad;
    exit_save = commit && (lnk.op == ecs_pkg::ECS_OP_ASYNC_EXIT) && (EXTRA_CAP != 32'h0);
  end

  // grant decision for key, debug and exit requests
  always_comb begin
    result_ok = 1'b0;
    unique case (lnk.op)
      ecs_pkg::ECS_OP_DEBUG: result_ok = attrib_o[ecs_pkg::ATTR_DEBUG_BIT];
      ecs_pkg::ECS_OP_KEY: begin
        unique case (lnk.key_sel)
          ecs_pkg::ECS_KEY_PROV:  result_ok = attrib_o[ecs_pkg::ATTR_PROV_KEY_BIT];
          ecs_pkg::ECS_KEY_TOKEN: result_ok = attrib_o[ecs_pkg::ATTR_TOKEN_KEY_BIT];
          default:                result_ok = 1'b1;
        endcase
      end
      ecs_pkg::ECS_OP_ASYNC_EXIT: result_ok = (EXTRA_CAP != 32'h0);
      default: result_ok = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // structure fields
  // ---------------------------------------------------------------
  // layout fields, committed only when the create passes
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      valid_o       <= 1'b0;
      size_o        <= 64'h0;
      base_o        <= 64'h0;
      frame_pages_o <= 32'h0;
      sel_q         <= 32'h0;
    end else if (commit && is_create) begin
      valid_o       <= 1'b1;
      size_o        <= lnk.size;
      base_o        <= lnk.base;
      frame_pages_o <= lnk.frame_pages;
      sel_q         <= lnk.extra_select;
    end
  end

  // creation counter hands each created structure its own ident
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ident_ctr_q     <= 64'h0;
      enclave_ident_o <= 64'h0;
    end else if (commit && is_create) begin
      ident_ctr_q     <= ident_ctr_q + 64'h1;
      enclave_ident_o <= ident_ctr_q;
    end
  end

  // attribute word; init bit set by a passing init
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      attrib_o <= 128'h0;
    end else if (commit) begin
      if (is_create) begin
        attrib_o <= lnk.attrib;
      end else if (lnk.op == ecs_pkg::ECS_OP_INIT) begin
        attrib_o[ecs_pkg::ATTR_INIT_BIT] <= 1'b1;
      end
    end
  end

  // build measurement accumulates, signer measurement extended at init
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      build_meas_o  <= ecs_pkg::MEAS_RESET;
      signer_meas_o <= ecs_pkg::MEAS_RESET;
    end else if (commit) begin
      unique case (lnk.op)
        ecs_pkg::ECS_OP_CREATE: begin
          build_meas_o  <= ecs_pkg::MEAS_RESET;
          signer_meas_o <= ecs_pkg::MEAS_RESET;
        end
        ecs_pkg::ECS_OP_EXTEND: build_meas_o  <= fold(build_meas_o, lnk.data);
        ecs_pkg::ECS_OP_INIT:   signer_meas_o <= fold(signer_meas_o, lnk.data);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // answer
  // ---------------------------------------------------------------
  // one-cycle answer pulses and the wide mode level
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lnk.done        <= 1'b0;
      lnk.violation   <= 1'b0;
      lnk.granted     <= 1'b0;
      lnk.extra_write <= 32'h0;
      lnk.wide_mode   <= 1'b0;
    end else begin
      lnk.done        <= lnk.req;
      lnk.violation   <= lnk.req && bad;
      lnk.granted     <= commit && result_ok;
      lnk.extra_write <= exit_save ? (sel_q & EXTRA_CAP) : 32'h0;
      lnk.wide_mode   <= attrib_o[ecs_pkg::ATTR_WIDE_BIT];
    end
  end
endmodule : ecs_checker

// [hdl/ecs_if.sv]
// interface: request/answer link between sequencer and structure checker
`timescale 1ns/100ps
interface ecs_if;
  logic               req;          // one-cycle request pulse
  ecs_pkg::ecs_op_t   op;           // operation code
  logic [63:0]        struct_addr;  // structure address (create)
  logic [63:0]        size;         // enclave size field
  logic [63:0]        base;         // enclave_base_addr field
  logic [31:0]        frame_pages;  // save_frame_pages field
  logic [31:0]        extra_select; // extra_state_select field
  logic [127:0]       attrib;       // attribute word or target info attributes
  logic [255:0]       data;         // measurement data / signer key digest
  logic [15:0]        product;      // product_ident
  logic [15:0]        secver;       // security_version
  logic               reserved_zero; // reserved area found all zero
  ecs_pkg::ecs_key_t  key_sel;      // requested key kind
  logic               done;         // one-cycle answer pulse
  logic               violation;    // check failed, nothing committed
  logic               granted;      // access or key granted
  logic [31:0]        extra_write;  // extra-state items to save on exit
  logic               wide_mode;    // enclave runs in wide mode

  modport dev (input req, op, struct_addr, size, base, frame_pages, extra_select, attrib, data,
               product, secver, reserved_zero, key_sel,
               output done, violation, granted, extra_write, wide_mode);
  modport seq (output req, op, struct_addr, size, base, frame_pages, extra_select, attrib, data,
               product, secver, reserved_zero, key_sel,
               input done, violation, granted, extra_write, wide_mode);
endinterface : ecs_if

// [hdl/ecs_pkg.sv]
// package: enclave control structure layout, attribute bits and checker constants
package ecs_pkg;
  // ---------------------------------------------------------------
  // structure layout (byte offsets and sizes)
  // ---------------------------------------------------------------
  localparam int unsigned ALIGN_BITS       = 12;   // 4 KiB structure alignment
  localparam int unsigned OFF_SIZE         = 0;
  localparam int unsigned LEN_SIZE         = 8;
  localparam int unsigned OFF_BASE         = 8;
  localparam int unsigned OFF_FRAME_PAGES  = 16;
  localparam int unsigned LEN_FRAME_PAGES  = 4;
  localparam int unsigned OFF_EXTRA_SELECT = 20;
  localparam int unsigned OFF_ATTRIB       = 48;
  localparam int unsigned LEN_ATTRIB       = 16;
  localparam int unsigned OFF_BUILD_MEAS   = 64;
  localparam int unsigned LEN_MEAS         = 32;
  localparam int unsigned OFF_SIGNER_MEAS  = 128;
  localparam int unsigned OFF_PRODUCT      = 256;
  localparam int unsigned OFF_SECVER       = 258;
  localparam int unsigned OFF_RESERVED     = 260;
  localparam int unsigned LEN_RESERVED     = 3836;
  localparam int unsigned LEN_IDENT        = 8;
  localparam int unsigned LEN_SIG_PAD      = 352;
  // chosen placement of ident and pad inside the reserved area
  localparam int unsigned OFF_IDENT        = 260;
  localparam int unsigned OFF_SIG_PAD      = 268;

  // ---------------------------------------------------------------
  // attribute and selection bits
  // ---------------------------------------------------------------
  localparam int unsigned ATTR_INIT_BIT      = 0;
  localparam int unsigned ATTR_DEBUG_BIT     = 1;
  localparam int unsigned ATTR_WIDE_BIT      = 2;
  localparam int unsigned ATTR_PROV_KEY_BIT  = 4;
  localparam int unsigned ATTR_TOKEN_KEY_BIT = 5;
  localparam logic [63:0] ATTR_DEFINED_MASK  = 64'h0000_0000_0000_0037;
  localparam int unsigned SEL_FAULT_INFO_BIT = 0;
  localparam logic [31:0] SEL_DEFINED_MASK   = 32'h0000_0001;

  // ---------------------------------------------------------------
  // operations and reset values
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ECS_OP_CREATE    = 3'h0,   // create_enclave_op
    ECS_OP_INIT      = 3'h1,   // init_enclave_op
    ECS_OP_EXTEND    = 3'h2,   // fold data into build measurement
    ECS_OP_REPORT    = 3'h3,   // report_gen_op
    ECS_OP_KEY       = 3'h4,   // key_derive_op
    ECS_OP_DEBUG     = 3'h5,   // debugger data access
    ECS_OP_ASYNC_EXIT = 3'h6   // async_exit
  } ecs_op_t;

  typedef enum logic [1:0] {
    ECS_KEY_OTHER  = 2'h0,
    ECS_KEY_PROV   = 2'h1,
    ECS_KEY_TOKEN  = 2'h2
  } ecs_key_t;

  localparam logic [255:0] MEAS_RESET = 256'h0;
endpackage : ecs_pkg

// [hdl/ecs_sequencer.sv]
// module: sequencer end that issues structure requests and collects answers
`timescale 1ns/100ps
module ecs_sequencer (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  ecs_if.seq                      lnk,
  input  wire logic               start_i,       // one-cycle command pulse
  input  wire ecs_pkg::ecs_op_t   op_i,
  input  wire logic [63:0]        struct_addr_i,
  input  wire logic [63:0]        size_i,
  input  wire logic [63:0]        base_i,
  input  wire logic [31:0]        frame_pages_i,
  input  wire logic [31:0]        extra_select_i,
  input  wire logic [127:0]       attrib_i,
  input  wire logic [255:0]       data_i,
  input  wire logic [15:0]        product_i,
  input  wire logic [15:0]        secver_i,
  input  wire logic               reserved_zero_i, // software zeroed reserved area
  input  wire ecs_pkg::ecs_key_t  key_sel_i,
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    violation_o,
  output logic                    granted_o,
  output logic [31:0]             extra_write_o
);
  typedef enum logic [1:0] {
    ECS_SQ_IDLE = 2'h0,
    ECS_SQ_WAIT = 2'h1
  } ecs_sq_state_t;

  ecs_sq_state_t state_q;

  // ---------------------------------------------------------------
  // request launch, one outstanding at a time
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q           <= ECS_SQ_IDLE;
      lnk.req           <= 1'b0;
      lnk.op            <= ecs_pkg::ECS_OP_CREATE;
      lnk.struct_addr   <= 64'h0;
      lnk.size          <= 64'h0;
      lnk.base          <= 64'h0;
      lnk.frame_pages   <= 32'h0;
      lnk.extra_select  <= 32'h0;
      lnk.attrib        <= 128'h0;
      lnk.data          <= 256'h0;
      lnk.product       <= 16'h0;
      lnk.secver        <= 16'h0;
      lnk.reserved_zero <= 1'b0;
      lnk.key_sel       <= ecs_pkg::ECS_KEY_OTHER;
      busy_o            <= 1'b0;
    end else begin
      lnk.req <= 1'b0;
      unique case (state_q)
        ECS_SQ_IDLE: if (start_i) begin
          lnk.req           <= 1'b1;
          lnk.op            <= op_i;
          lnk.struct_addr   <= struct_addr_i;
          lnk.size          <= size_i;
          lnk.base          <= base_i;
          lnk.frame_pages   <= frame_pages_i;
          lnk.extra_select  <= extra_select_i;
          lnk.attrib        <= attrib_i;
          lnk.data          <= data_i;
          lnk.product       <= product_i;
          lnk.secver        <= secver_i;
          lnk.reserved_zero <= reserved_zero_i;
          lnk.key_sel       <= key_sel_i;
          busy_o            <= 1'b1;
          state_q           <= ECS_SQ_WAIT;
        end
        ECS_SQ_WAIT: if (lnk.done) begin
          busy_o  <= 1'b0;
          state_q <= ECS_SQ_IDLE;
        end
      endcase
    end
  end

  // answers passed up one cycle after the link answer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_o        <= 1'b0;
      violation_o   <= 1'b0;
      granted_o     <= 1'b0;
      extra_write_o <= 32'h0;
    end else begin
      done_o        <= lnk.done;
      violation_o   <= lnk.done && lnk.violation;
      granted_o     <= lnk.done && lnk.granted;
      extra_write_o <= lnk.done ? lnk.extra_write : 32'h0;
    end
  end
endmodule : ecs_sequencer

// [testbench/ecs_checker_tb.sv]
// testbench: sequencer and structure checker joined over the link
`timescale 1ns/100ps
module ecs_checker_tb;
  logic              mclk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              start = 1'b0;
  ecs_pkg::ecs_op_t  op = ecs_pkg::ECS_OP_CREATE;
  ecs_pkg::ecs_key_t key = ecs_pkg::ECS_KEY_OTHER;
  logic [63:0]       addr, size, base, sz_o, bs_o, id_o;
  logic [31:0]       pages, sel, xw, pg_o;
  logic [127:0]      attrib, at_o;
  logic [255:0]      data, bm_o, sm_o, d1;
  logic              rz, busy, fin, viol, gr, valid;
  int                n_mismatch = 0;
  int                n_tests = 0;

  ecs_if lnk();
  ecs_sequencer ecs_sequencer_i (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(lnk), .start_i(start), .op_i(op),
    .struct_addr_i(addr), .size_i(size), .base_i(base), .frame_pages_i(pages), .extra_select_i(sel),
    .attrib_i(attrib), .data_i(data), .product_i(16'h0102), .secver_i(16'h0003), .reserved_zero_i(rz),
    .key_sel_i(key), .busy_o(busy), .done_o(fin), .violation_o(viol), .granted_o(gr), .extra_write_o(xw));
  ecs_checker ecs_checker_i (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(lnk), .valid_o(valid), .size_o(sz_o),
    .base_o(bs_o), .frame_pages_o(pg_o), .attrib_o(at_o), .build_meas_o(bm_o), .signer_meas_o(sm_o),
    .enclave_ident_o(id_o));
  ecs_link_monitor ecs_link_monitor_i (.mclk_i(mclk_i), .reset_i(reset_i), .req(lnk.req), .op(lnk.op),
    .struct_addr(lnk.struct_addr), .size(lnk.size), .base(lnk.base), .frame_pages(lnk.frame_pages),
    .extra_select(lnk.extra_select), .attrib(lnk.attrib), .reserved_zero(lnk.reserved_zero), .done(lnk.done),
    .violation(lnk.violation), .granted(lnk.granted), .extra_write(lnk.extra_write));

  // clock and watchdog
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    n_mismatch++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // one command: start pulse, bounded wait for the answer
  task automatic go(input ecs_pkg::ecs_op_t o);
    int i;
    op = o;
    start = 1'b1;
    @(posedge mclk_i);
    #1 start = 1'b0;
    chk("busy", busy, 1'b1);
    for (i = 0; i < 8 && fin !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    chk("latency", i + 1, 3);
    chk("idle", busy, 1'b0);
  endtask : go
  task automatic set_good();
    addr = 64'h0000_0000_0004_0000;
    size = 64'h0000_0000_0010_0000;
    base = 64'h0000_0000_0020_0000;
    pages = 32'h0000_0001;
    sel = 32'h0000_0001;
    attrib = {64'h0000_0000_0000_0007, 64'h0000_0000_0000_0016};
    rz = 1'b1;
  endtask : set_good

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_bad_create();
    for (int k = 0; k < 9; k++) begin
      set_good();
      case (k)
        0: addr = 64'h0000_0000_0004_0800;
        1: size = 64'h0000_0000_0018_0000;
        2: base = 64'h0000_0000_0028_0000;
        3: pages = 32'h0000_0000;
        4: attrib[0] = 1'b1;
        5: attrib[3] = 1'b1;
        6: attrib[6] = 1'b1;
        7: sel = 32'h0000_0002;
        default: rz = 1'b0;
      endcase
      go(ecs_pkg::ECS_OP_CREATE);
      chk("violation", viol, 1'b1);
      chk("valid", valid, 1'b0);
      chk("size kept", sz_o, 64'h0);
    end
    $display("test bad_create finished");
  endtask : t_bad_create
  task automatic t_create(input logic [63:0] ident, input logic [63:0] lo);
    set_good();
    attrib[63:0] = lo;
    go(ecs_pkg::ECS_OP_CREATE);
    chk("violation", viol, 1'b0);
    chk("valid", valid, 1'b1);
    chk("size", sz_o, size);
    chk("base", bs_o, base);
    chk("pages", pg_o, pages);
    chk("attrib", at_o, attrib);
    chk("build", bm_o, 256'h0);
    chk("ident", id_o, ident);
    chk("wide", lnk.wide_mode, lo[2]);
    chk("product", lnk.product, 16'h0102);
    chk("version", lnk.secver, 16'h0003);
    $display("test create finished");
  endtask : t_create
  task automatic t_keys(input logic prov, input logic token, input logic dbg);
    key = ecs_pkg::ECS_KEY_PROV;
    go(ecs_pkg::ECS_OP_KEY);
    chk("prov key", gr, prov);
    key = ecs_pkg::ECS_KEY_TOKEN;
    go(ecs_pkg::ECS_OP_KEY);
    chk("token key", gr, token);
    key = ecs_pkg::ECS_KEY_OTHER;
    go(ecs_pkg::ECS_OP_KEY);
    chk("other key", gr, 1'b1);
    go(ecs_pkg::ECS_OP_DEBUG);
    chk("debug", gr, dbg);
    $display("test keys finished");
  endtask : t_keys
  task automatic t_build();
    d1 = {8{32'hA5C3_0F01}};
    data = d1;
    go(ecs_pkg::ECS_OP_EXTEND);
    chk("build 1", bm_o, d1);
    data = {8{32'h1234_8765}};
    go(ecs_pkg::ECS_OP_EXTEND);
    d1 = {d1[254:0], d1[255]} ^ data;
    chk("build 2", bm_o, d1);
    data = {8{32'h0F0F_3C3C}};
    go(ecs_pkg::ECS_OP_INIT);
    chk("signer", sm_o, data);
    chk("init bit", at_o[0], 1'b1);
    go(ecs_pkg::ECS_OP_EXTEND);
    chk("late extend", viol, 1'b1);
    chk("build kept", bm_o, d1);
    go(ecs_pkg::ECS_OP_INIT);
    chk("second init", viol, 1'b1);
    $display("test build finished");
  endtask : t_build
  task automatic t_report_exit();
    attrib[0] = 1'b0;
    go(ecs_pkg::ECS_OP_REPORT);
    chk("target init", viol, 1'b1);
    attrib[0] = 1'b1;
    go(ecs_pkg::ECS_OP_REPORT);
    chk("report ok", viol, 1'b0);
    rz = 1'b0;
    go(ecs_pkg::ECS_OP_REPORT);
    chk("report area", viol, 1'b1);
    sel = 32'hFFFF_FFFF;
    go(ecs_pkg::ECS_OP_ASYNC_EXIT);
    chk("exit grant", gr, 1'b1);
    chk("exit save", xw, 32'h0000_0001);
    $display("test report_exit finished");
  endtask : t_report_exit

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    set_good();
    data = 256'h0;
    repeat (6) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    t_bad_create();
    t_create(64'h0, 64'h0000_0000_0000_0016);
    t_keys(1'b1, 1'b0, 1'b1);
    t_build();
    t_report_exit();
    t_create(64'h1, 64'h0000_0000_0000_0020);
    t_keys(1'b0, 1'b1, 1'b0);
    stop_test();
  end
endmodule : ecs_checker_tb

// [testbench/ecs_link_monitor.sv]
// checker: link-level assertions between the sequencer and the structure checker
`timescale 1ns/100ps
module ecs_link_monitor #(
  parameter logic [31:0] EXTRA_CAP = 32'h0000_0001
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             req,
  input  wire ecs_pkg::ecs_op_t op,
  input  wire logic [63:0]      struct_addr,
  input  wire logic [63:0]      size,
  input  wire logic [63:0]      base,
  input  wire logic [31:0]      frame_pages,
  input  wire logic [31:0]      extra_select,
  input  wire logic [127:0]     attrib,
  input  wire logic             reserved_zero,
  input  wire logic             done,
  input  wire logic             violation,
  input  wire logic             granted,
  input  wire logic [31:0]      extra_write
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // create request seen on the link
  logic mk;
  assign mk = req && (op == ecs_pkg::ECS_OP_CREATE);
  // selection vector of the last create that passed
  logic [31:0] sel_seen_q;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sel_seen_q <= 32'h0;
    end else if (done && !violation && op == ecs_pkg::ECS_OP_CREATE) begin
      sel_seen_q <= extra_select;
    end
  end

  // ---------------------------------------------------------------
  // answer timing
  // ---------------------------------------------------------------
  a_answer_next_cycle: assert property (req |=> done)
    else $error("no answer one cycle after request");
  a_answer_has_cause: assert property (done |-> $past(req))
    else $error("answer without request");

  // ---------------------------------------------------------------
  // create and report checks
  // ---------------------------------------------------------------
  a_create_align: assert property (mk && struct_addr[11:0] != 12'h000 |=> violation)
    else $error("misaligned structure accepted");
  a_size_pow_two: assert property (mk && (size & (size - 64'h1)) != 64'h0 |=> violation)
    else $error("size not power of two accepted");
  a_base_natural: assert property (mk && size != 64'h0 && (base & (size - 64'h1)) != 64'h0 |=> violation)
    else $error("base not aligned to size accepted");
  a_frame_nonzero: assert property (mk && frame_pages == 32'h0 |=> violation)
    else $error("zero frame size accepted");
  a_attr_permit: assert property (mk && (attrib[63:0] & ~ecs_pkg::ATTR_DEFINED_MASK) != 64'h0 |=> violation)
    else $error("unpermitted attribute accepted");
  a_init_on_create: assert property (mk && attrib[0] |=> violation)
    else $error("init bit accepted on create");
  a_select_reserved: assert property (mk && (extra_select[31:1] != 31'h0 || (EXTRA_CAP == 32'h0 && extra_select != 32'h0))
                                      |=> violation)
    else $error("reserved selection accepted");
  a_area_zeroed: assert property (req && (mk || op == ecs_pkg::ECS_OP_REPORT) && !reserved_zero |=> violation)
    else $error("unzeroed reserved area accepted");
  a_report_target: assert property (req && op == ecs_pkg::ECS_OP_REPORT && !attrib[0] |=> violation)
    else $error("report target without init accepted");

  // ---------------------------------------------------------------
  // refusal and exit saving
  // ---------------------------------------------------------------
  a_refuse_nothing: assert property (violation |-> !granted && extra_write == 32'h0)
    else $error("refused request still granted");
  a_exit_select: assert property (req && op == ecs_pkg::ECS_OP_ASYNC_EXIT
                                  |=> violation || extra_write == (sel_seen_q & EXTRA_CAP))
    else $error("exit save set wrong");

  c_create_pass: cover property (mk ##1 (done && !violation));
  c_refused: cover property (done && violation);
  c_exit_save: cover property (done && extra_write != 32'h0);
endmodule : ecs_link_monitor
